// *** logic/fdo_pkg.sv ***
// package for the debug speed_source_select register bank: offsets, field positions,
// reset values and decoded-speed_source_select structs.
// assumes a register write port of byte offset, 32-bit data and strobe.
package fdo_pkg;

    localparam logic [7:0]  SPEED_STARTUP_OFFSET = 8'hEC;
    localparam logic [7:0]  LOOP_MEASURE_OFFSET  = 8'hEE;
    localparam logic [31:0] REG_RESET            = 32'h0000_0000;

    // speed_and_startup_speed_source_select fields
    localparam int SPEED_SOURCE_BIT   = 31;
    localparam int SPEED_VALUE_MSB    = 30;
    localparam int SPEED_VALUE_LSB    = 16;
    localparam int CLOSED_LOOP_BIT    = 15;
    localparam int HOLD_ALIGN_BIT     = 14;
    localparam int HOLD_SLOW_BIT      = 13;
    localparam int HOLD_IPD_BIT       = 12;
    localparam int HOLD_ISD_BIT       = 11;
    localparam int ALIGN_SRC_BIT      = 10;
    localparam int IQ_MSB             = 9;
    localparam int IQ_LSB             = 0;

    // loop_and_measurement_speed_source_select fields
    localparam int STOP_SECTOR_MSB    = 30;
    localparam int STOP_SECTOR_LSB    = 28;
    localparam int RECIRC_EN_BIT      = 27;
    localparam int CURRENT_LOOP_BIT   = 26;
    localparam int VD_MSB             = 25;
    localparam int VD_LSB             = 16;
    localparam int VQ_MSB             = 15;
    localparam int VQ_LSB             = 6;
    localparam int MEASURE_START_BIT  = 5;
    localparam int MEASURE_SEL_MSB    = 4;
    localparam int MEASURE_SEL_LSB    = 0;

    // signed reference coding: code/500, or (code-1024)/500 above 512
    localparam logic [9:0]  REF_SCALE     = 10'h1F4;
    localparam logic [9:0]  REF_NEG_START = 10'h200;
    localparam logic [10:0] REF_WRAP      = 11'h400;

    // startup methods that the hold bits qualify
    typedef enum logic [2:0] {
        FDO_START_ALIGN        = 3'b000,
        FDO_START_DOUBLE_ALIGN = 3'b001,
        FDO_START_IPD          = 3'b010,
        FDO_START_SLOW_CYCLE   = 3'b011
    } fdo_startup_t;

    typedef struct packed {
        logic [14:0] speed_request;
        logic        speed_from_serial;
        logic        closed_loop_off;
        logic        hold_align;
        logic        hold_slow_first_cycle;
        logic        hold_initial_position_detect;
        logic        hold_initial_speed_detect;
        logic        align_from_runtime;
    } fdo_speed_ctl_t;

    typedef struct packed {
        logic        current_loop_off;
        logic        speed_loop_off;
        logic [10:0] torque_current_ref;
        logic [10:0] direct_voltage_ref;
        logic [10:0] quadrature_voltage_ref;
    } fdo_loop_ctl_t;

endpackage : fdo_pkg

// *** logic/fdo_ref_decode.sv ***
// converts a 10-bit speed_source_select code into a signed 11-bit numerator over 500.
// assumes codes within 0..500 or 513..1000; codes 501..512 decode to zero, codes above 1000 still wrap to negative.
`timescale 1ns/1ns
module fdo_ref_decode (
    input  wire logic [9:0]  i_code,
    output logic      [10:0] o_ref
);
    always_comb begin
        if (i_code <= fdo_pkg::REF_SCALE) begin
            o_ref = {1'b0, i_code};
        end else if (i_code > fdo_pkg::REF_NEG_START) begin
            o_ref = {1'b0, i_code} - fdo_pkg::REF_WRAP;
        end else begin
            o_ref = 11'h000;
        end
    end
endmodule : fdo_ref_decode

// *** logic/fdo_speed_source_select_regs.sv ***
// debug speed_source_select register bank: two write-only registers steering speed
// source, loop enables, startup holds and measurement launch.
// assumes a single-cycle write strobe with byte offset and 32-bit data.
//
// Functional notes
// - bit 31 picks serial speed value instead of analog or PWM input
// - serial speed request taken from bits 30..16 when source bit set
// - bit 15 set forces open-loop commutation, clear keeps closed loop
// - bit 14 holds align state for align or double-align startup
// - bit 13 holds slow-first-cycle state for that startup method
// - bit 12 holds initial position detection state for that method
// - bit 11 holds initial speed detection when that detection enabled
// - bit 10 picks runtime align angle over preset angle
// - speed loop off drives torque reference from bits 9..0, scaled /500
// - current loop off disables both loops, applies forced Vd and Vq
// - writing one to measurement start bit launches parameter measurement
// - voltage codes map to code/500 or (code-1024)/500 of reference
`timescale 1ns/1ns
module fdo_speed_source_select_regs (
    input  wire logic                   I_SYS_CLK,
    input  wire logic                   I_RST,
    input  wire logic                   I_WR_EN,
    input  wire logic [7:0]             I_WR_ADDR,
    input  wire logic [31:0]            I_WR_DATA,
    input  wire logic [2:0]             I_STARTUP_METHOD,
    input  wire logic                   I_ISD_ENABLE,
    input  wire logic                   I_SPEED_LOOP_OFF,
    input  wire logic [14:0]            I_ANALOG_SPEED,
    input  wire logic [8:0]             I_PRESET_ALIGN_ANGLE,
    input  wire logic [8:0]             I_RUNTIME_ALIGN_ANGLE,
    output fdo_pkg::fdo_speed_ctl_t     O_SPEED_CTL,
    output fdo_pkg::fdo_loop_ctl_t      O_LOOP_CTL,
    output logic      [14:0]            O_SPEED_CMD,
    output logic      [8:0]             O_ALIGN_ANGLE,
    output logic      [2:0]             O_STOP_SECTOR,
    output logic                        O_RECIRC_STOP_OFF,
    output logic      [4:0]             O_MEASURE_SELECT,
    output logic                        O_MEASURE_START
);
    logic [31:0] speed_reg;
    logic [31:0] loop_reg;
    logic [10:0] iq_ref;
    logic [10:0] vd_ref;
    logic [10:0] vq_ref;
    logic        method_align;

    // write decode; both registers clear on reset
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            speed_reg <= fdo_pkg::REG_RESET;
        end else if (I_WR_EN &&
                     I_WR_ADDR == fdo_pkg::SPEED_STARTUP_OFFSET) begin
            speed_reg <= I_WR_DATA;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            loop_reg <= fdo_pkg::REG_RESET;
        end else if (I_WR_EN &&
                     I_WR_ADDR == fdo_pkg::LOOP_MEASURE_OFFSET) begin
            loop_reg <= I_WR_DATA;
        end
    end

    // one-cycle launch pulse per write of a one
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_MEASURE_START <= 1'b0;
        end else begin
            O_MEASURE_START <= I_WR_EN &&
                I_WR_ADDR == fdo_pkg::LOOP_MEASURE_OFFSET &&
                I_WR_DATA[fdo_pkg::MEASURE_START_BIT];
        end
    end

    fdo_ref_decode u_iq (
        .i_code (speed_reg[fdo_pkg::IQ_MSB:fdo_pkg::IQ_LSB]),
        .o_ref  (iq_ref)
    );
    fdo_ref_decode u_vd (
        .i_code (loop_reg[fdo_pkg::VD_MSB:fdo_pkg::VD_LSB]),
        .o_ref  (vd_ref)
    );
    fdo_ref_decode u_vq (
        .i_code (loop_reg[fdo_pkg::VQ_MSB:fdo_pkg::VQ_LSB]),
        .o_ref  (vq_ref)
    );

    assign method_align =
        I_STARTUP_METHOD == fdo_pkg::FDO_START_ALIGN ||
        I_STARTUP_METHOD == fdo_pkg::FDO_START_DOUBLE_ALIGN;

    // registered speed_source_select controls
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_SPEED_CTL <= '0;
            O_SPEED_CMD <= 15'h0000;
        end else begin
            O_SPEED_CTL.speed_from_serial <=
                speed_reg[fdo_pkg::SPEED_SOURCE_BIT];
            O_SPEED_CTL.speed_request <=
                speed_reg[fdo_pkg::SPEED_VALUE_MSB:fdo_pkg::SPEED_VALUE_LSB];
            O_SPEED_CMD <= speed_reg[fdo_pkg::SPEED_SOURCE_BIT] ?
                speed_reg[fdo_pkg::SPEED_VALUE_MSB:fdo_pkg::SPEED_VALUE_LSB]
                : I_ANALOG_SPEED;
            O_SPEED_CTL.closed_loop_off <=
                speed_reg[fdo_pkg::CLOSED_LOOP_BIT];
            O_SPEED_CTL.hold_align <=
                speed_reg[fdo_pkg::HOLD_ALIGN_BIT] && method_align;
            O_SPEED_CTL.hold_slow_first_cycle <=
                speed_reg[fdo_pkg::HOLD_SLOW_BIT] &&
                I_STARTUP_METHOD == fdo_pkg::FDO_START_SLOW_CYCLE;
            O_SPEED_CTL.hold_initial_position_detect <=
                speed_reg[fdo_pkg::HOLD_IPD_BIT] &&
                I_STARTUP_METHOD == fdo_pkg::FDO_START_IPD;
            O_SPEED_CTL.hold_initial_speed_detect <=
                speed_reg[fdo_pkg::HOLD_ISD_BIT] && I_ISD_ENABLE;
            O_SPEED_CTL.align_from_runtime <=
                speed_reg[fdo_pkg::ALIGN_SRC_BIT];
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_ALIGN_ANGLE <= 9'h000;
        end else begin
            O_ALIGN_ANGLE <= speed_reg[fdo_pkg::ALIGN_SRC_BIT] ?
                I_RUNTIME_ALIGN_ANGLE : I_PRESET_ALIGN_ANGLE;
        end
    end

    // current loop off forces both loops off and the voltage references
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_LOOP_CTL <= '0;
        end else begin
            O_LOOP_CTL.current_loop_off <=
                loop_reg[fdo_pkg::CURRENT_LOOP_BIT];
            O_LOOP_CTL.speed_loop_off <= I_SPEED_LOOP_OFF ||
                loop_reg[fdo_pkg::CURRENT_LOOP_BIT];
            O_LOOP_CTL.torque_current_ref <=
                (I_SPEED_LOOP_OFF && !loop_reg[fdo_pkg::CURRENT_LOOP_BIT])
                ? iq_ref : 11'h000;
            O_LOOP_CTL.direct_voltage_ref <=
                loop_reg[fdo_pkg::CURRENT_LOOP_BIT] ? vd_ref : 11'h000;
            O_LOOP_CTL.quadrature_voltage_ref <=
                loop_reg[fdo_pkg::CURRENT_LOOP_BIT] ? vq_ref : 11'h000;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_STOP_SECTOR     <= 3'h0;
            O_RECIRC_STOP_OFF <= 1'b0;
            O_MEASURE_SELECT  <= 5'h00;
        end else begin
            O_STOP_SECTOR <=
                loop_reg[fdo_pkg::STOP_SECTOR_MSB:fdo_pkg::STOP_SECTOR_LSB];
            O_RECIRC_STOP_OFF <= loop_reg[fdo_pkg::RECIRC_EN_BIT];
            O_MEASURE_SELECT <=
                loop_reg[fdo_pkg::MEASURE_SEL_MSB:fdo_pkg::MEASURE_SEL_LSB];
        end
    end

    chk_serial_speed_cmd: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) speed_reg[31] |=> O_SPEED_CMD ==
        $past(speed_reg[30:16])) else $error("speed cmd not serial");
    chk_analog_speed_cmd: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) !speed_reg[31] |=> O_SPEED_CMD ==
        $past(I_ANALOG_SPEED)) else $error("speed cmd not analog");
    chk_open_loop: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) speed_reg[15] |=> O_SPEED_CTL.closed_loop_off)
        else $error("closed loop not off");
    chk_hold_align: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) (speed_reg[14] && method_align) |=>
        O_SPEED_CTL.hold_align) else $error("align hold lost");
    chk_hold_unqualified: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) !method_align |=> !O_SPEED_CTL.hold_align)
        else $error("align hold without align startup");
    chk_hold_slow: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) !speed_reg[13] |=>
        !O_SPEED_CTL.hold_slow_first_cycle) else $error("slow hold");
    chk_hold_ipd: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) !speed_reg[12] |=>
        !O_SPEED_CTL.hold_initial_position_detect)
        else $error("ipd hold");
    chk_hold_isd: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) (speed_reg[11] && I_ISD_ENABLE) |=>
        O_SPEED_CTL.hold_initial_speed_detect) else $error("isd hold");
    chk_align_source: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) speed_reg[10] |=> O_ALIGN_ANGLE ==
        $past(I_RUNTIME_ALIGN_ANGLE)) else $error("align angle src");
    chk_iq_negative: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) (I_SPEED_LOOP_OFF && !loop_reg[26] &&
        speed_reg[9:0] == 10'h3E8) |=>
        O_LOOP_CTL.torque_current_ref == 11'h7E8)
        else $error("iq code 1000 wrong");
    chk_current_loop_off: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) loop_reg[26] |=> O_LOOP_CTL.speed_loop_off &&
        O_LOOP_CTL.direct_voltage_ref == $past(vd_ref))
        else $error("current loop off");
    chk_measure_pulse: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) O_MEASURE_START |=> !O_MEASURE_START ||
        $past(I_WR_EN)) else $error("launch pulse stuck");
    chk_measure_launch: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) (I_WR_EN &&
        I_WR_ADDR == fdo_pkg::LOOP_MEASURE_OFFSET &&
        I_WR_DATA[fdo_pkg::MEASURE_START_BIT]) |=> O_MEASURE_START)
        else $error("launch pulse missing");
    chk_vq_scale: assert property (@(posedge I_SYS_CLK)
        disable iff (I_RST) (loop_reg[26] && loop_reg[15:6] == 10'h1F4) |=>
        O_LOOP_CTL.quadrature_voltage_ref == 11'h1F4)
        else $error("vq scale");
    chk_reset_clear: assert property (@(posedge I_SYS_CLK)
        $past(I_RST) |-> speed_reg == 32'h0000_0000 &&
        loop_reg == 32'h0000_0000) else $error("regs not clear");

    cov_serial_speed: cover property (@(posedge I_SYS_CLK)
        disable iff (I_RST) O_SPEED_CTL.speed_from_serial);
    cov_measure: cover property (@(posedge I_SYS_CLK)
        disable iff (I_RST) O_MEASURE_START);
    cov_cur_off: cover property (@(posedge I_SYS_CLK)
        disable iff (I_RST) O_LOOP_CTL.current_loop_off);
endmodule : fdo_speed_source_select_regs

// *** verification/fdo_host_model.sv ***
// host model: sends whole-word writes to the debug speed_source_select registers.
// assumes the block samples the strobe on the rising clock edge.
`timescale 1ns/1ns
module fdo_host_model (
    input  wire logic        i_clk,
    output logic             o_wr_en,
    output logic [7:0]       o_wr_addr,
    output logic [31:0]      o_wr_data
);
    initial begin
        o_wr_en   = 1'b0;
        o_wr_addr = 8'h00;
        o_wr_data = 32'h0000_0000;
    end

    // one strobe per word; released lines show the inverted last value
    task automatic put(input logic [7:0] addr, input logic [31:0] data);
        @(negedge i_clk);
        o_wr_en   = 1'b1;
        o_wr_addr = addr;
        o_wr_data = data;
        @(negedge i_clk);
        o_wr_en   = 1'b0;
        o_wr_addr = ~addr;
        o_wr_data = ~data;
    endtask : put
endmodule : fdo_host_model

// *** verification/fdo_speed_source_select_regs_tb.sv ***
// testbench for the debug speed_source_select register bank.
// assumes outputs settle two edges after a write strobe.
`timescale 1ns/1ns
module fdo_speed_source_select_regs_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   wr_en;
    logic [7:0]             wr_addr;
    logic [31:0]            wr_data;
    logic [2:0]             method = 3'h0;
    logic                   initial_speed_detect_enable = 1'b1;
    logic                   sl_off = 1'b0;
    logic [14:0]            analog = 15'h0ABC;
    fdo_pkg::fdo_speed_ctl_t sc;
    fdo_pkg::fdo_loop_ctl_t  lc;
    logic [14:0]            speed_cmd;
    logic [8:0]             angle;
    logic [2:0]             stop_sector;
    logic                   recirc;
    logic [4:0]             msel;
    logic                   mstart;
    int                     n_mismatch = 0;
    int                     cmp_count = 0;

    always #10 clk = ~clk;

    fdo_host_model host_u (.i_clk(clk), .o_wr_en(wr_en),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data));

    fdo_speed_source_select_regs dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_WR_EN(wr_en),
        .I_WR_ADDR(wr_addr), .I_WR_DATA(wr_data), .I_STARTUP_METHOD(method),
        .I_ISD_ENABLE(initial_speed_detect_enable), .I_SPEED_LOOP_OFF(sl_off),
        .I_ANALOG_SPEED(analog), .I_PRESET_ALIGN_ANGLE(9'h05A),
        .I_RUNTIME_ALIGN_ANGLE(9'h12D), .O_SPEED_CTL(sc), .O_LOOP_CTL(lc),
        .O_SPEED_CMD(speed_cmd), .O_ALIGN_ANGLE(angle),
        .O_STOP_SECTOR(stop_sector), .O_RECIRC_STOP_OFF(recirc),
        .O_MEASURE_SELECT(msel), .O_MEASURE_START(mstart));

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        host_u.put(addr, data);
        repeat (3) @(negedge clk);
    endtask : wr

    task automatic test_speed_source;
        wr(8'hEC, {1'b0, 15'h1234, 16'h0000});
        check(speed_cmd, analog);
        check(sc.speed_from_serial, 1'b0);
        wr(8'hEC, {1'b1, 15'h1234, 16'h0000});
        check(speed_cmd, 15'h1234);
        check(sc.speed_request, 15'h1234);
        check(sc.speed_from_serial, 1'b1);
    endtask : test_speed_source

    // one flag at a time, with the qualifying startup method selected
    task automatic test_flags;
        for (int b = 10; b < 16; b++) begin
            method = (b == 13) ? 3'h3 : (b == 12) ? 3'h2 : 3'h0;
            wr(8'hEC, 32'h0000_0001 << b);
            check({sc.closed_loop_off, sc.hold_align, sc.hold_slow_first_cycle,
                sc.hold_initial_position_detect, sc.hold_initial_speed_detect,
                sc.align_from_runtime}, 6'h01 << (b - 10));
            check(angle, (b == 10) ? 9'h12D : 9'h05A);
        end
        method = 3'h1;
        wr(8'hEC, 32'h0000_4000);
        check(sc.hold_align, 1'b1);
        // hold bits without their qualifying startup or detection enable
        method = 3'h3;
        initial_speed_detect_enable = 1'b0;
        wr(8'hEC, 32'h0000_5800);
        check({sc.hold_align, sc.hold_initial_position_detect,
            sc.hold_initial_speed_detect}, 3'h0);
        initial_speed_detect_enable = 1'b1;
    endtask : test_flags

    // codes inside the valid ranges plus 512, which decodes to zero
    task automatic test_torque;
        logic [9:0]  code [6] = '{10'h000, 10'h001, 10'h1F4, 10'h200, 10'h201,
            10'h3E8};
        logic [10:0] exp  [6] = '{11'h000, 11'h001, 11'h1F4, 11'h000, 11'h601,
            11'h7E8};
        sl_off = 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(8'hEC, {22'h000000, code[i]});
            check(lc.torque_current_ref, exp[i]);
        end
        sl_off = 1'b0;
        repeat (2) @(negedge clk);
        check(lc.torque_current_ref, 11'h000);
    endtask : test_torque

    task automatic test_current_loop;
        sl_off = 1'b1;
        wr(8'hEE, {1'b0, 3'h5, 1'b1, 1'b1, 10'h1F4, 10'h3E8, 6'h00});
        check({lc.current_loop_off, lc.speed_loop_off}, 2'b11);
        check(lc.torque_current_ref, 11'h000);
        check(lc.direct_voltage_ref, 11'h1F4);
        check(lc.quadrature_voltage_ref, 11'h7E8);
        check({stop_sector, recirc}, 4'hB);
        sl_off = 1'b0;
        repeat (2) @(negedge clk);
        check(lc.speed_loop_off, 1'b1);
        check(lc.torque_current_ref, 11'h000);
    endtask : test_current_loop

    task automatic test_measure;
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            host_u.put(8'hEE, (k == 1) ? 32'h0000_0035 : 32'h0000_0015);
            for (int c = 0; c < 6; c++) begin
                n += (mstart === 1'b0) ? 0 : 1;
                @(negedge clk);
            end
            check(n, k);
            check(msel, 5'h15);
        end
        wr(8'hEA, 32'hFFFF_FFFF);
        check({lc, msel, mstart}, {35'h0, 5'h15, 1'b0});
    endtask : test_measure

    // mid-run reset must clear every speed_source_select again
    task automatic test_reset;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(sc, 22'h000000);
        check(lc, 35'h0);
        check({stop_sector, recirc, msel, mstart}, 10'h000);
        check(speed_cmd, analog);
    endtask : test_reset

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(sc, 22'h000000);
        check(lc, 35'h0);
        check({stop_sector, recirc, msel, mstart}, 10'h000);
        test_speed_source();
        test_flags();
        test_torque();
        test_current_loop();
        test_measure();
        test_reset();
        end_sim();
    end
endmodule : fdo_speed_source_select_regs_tb
